// ---- logic/ppc_pkg.sv ----
/*
  Constants and carrier types for the PWM predivider and PLL control block.
  Assumes a single 40 MHz bus clock and an AHB-Lite register master.
*/
package ppc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [11:0] PPC_CFG_OFFSET  = 12'h060;
  localparam int          PPC_ADDR_W      = 12;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int          PPC_PSEL_HI     = 19;
  localparam int          PPC_PSEL_LO     = 17;
  localparam int          PPC_RSV_HI      = 16;
  localparam int          PPC_RSV_LO      = 14;
  localparam int          PPC_PDN_BIT     = 13;
  localparam int          PPC_ODRV_BIT    = 12;
  localparam int          PPC_BYP_BIT     = 11;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [2:0]  PPC_PSEL_RST    = 3'h7;
  localparam logic [2:0]  PPC_RSV_RST     = 3'h0;
  localparam logic        PPC_PDN_RST     = 1'h1;
  localparam logic        PPC_ODRV_RST    = 1'h1;
  localparam logic        PPC_BYP_RST     = 1'h1;

  // ==========================================================================
  // Divider and bus transfer constants
  // ==========================================================================
  localparam int          PPC_CNT_W       = 6;
  localparam logic [2:0]  PPC_DIV_MAXCODE = 3'h5;
  localparam logic [1:0]  PPC_HTRANS_NSEQ = 2'h2;
  localparam logic [2:0]  PPC_HSIZE_WORD  = 3'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [2:0] pwm_predivide_sel;
    logic [2:0] reserved;
    logic       pll_power_down;
    logic       pll_output_drive_en;
    logic       bypass;
  } ppc_cfg_t;

  typedef enum logic [1:0] {
    PPC_SW_OSC = 2'b01,
    PPC_SW_PLL = 2'b10
  } ppc_sw_t;

  typedef struct packed {
    ppc_cfg_t              cfg;
    logic                  wr_pend;
    logic [PPC_ADDR_W-1:0] wr_addr;
    logic                  rd_hit;
    logic [31:0]           hrdata;
    logic [PPC_CNT_W-1:0]  pwm_cnt;
    logic                  pwm_tick;
    logic                  pll_running;
    ppc_sw_t               sw_state;
    logic                  sel_osc;
    logic                  sel_pll;
  } ppc_state_t;

endpackage

// ---- logic/ppc_top.sv ----
/*
  Run-mode clock configuration slice: PWM predivider, PLL power-down and
  output drive control, and system clock source select, on AHB-Lite.
  Assumes the clock gating cells downstream use the mutually exclusive select outputs,
  and that the PLL and oscillator clocks are muxed outside this logic.
*/
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module ppc_top
  import ppc_pkg::*;
#(
  parameter int ADDR_W = PPC_ADDR_W
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [2:0]        pwm_predivide_sel,
  output logic                   pwm_clk_tick,
  output logic                   pll_power_down,
  output logic                   pll_output_drive_en,
  output logic                   pll_running,
  output logic                   sysclk_sel_osc,
  output logic                   sysclk_sel_pll
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (ADDR_W != PPC_ADDR_W) begin : g_bad_addr
    $error("ppc_top: ADDR_W must match the package address width.");
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Terminal count for the PWM divider; codes past the largest saturate.
  function automatic logic [PPC_CNT_W-1:0] pwm_term(input logic [2:0] sel);
    logic [2:0] eff;
    eff = (sel > PPC_DIV_MAXCODE) ? PPC_DIV_MAXCODE : sel;
    pwm_term = PPC_CNT_W'((2 << eff) - 1);
  endfunction

  function automatic logic [31:0] cfg_word(input ppc_cfg_t c);
    logic [31:0] w;
    w = '0;
    w[PPC_PSEL_HI:PPC_PSEL_LO]     = c.pwm_predivide_sel;
    w[PPC_RSV_HI:PPC_RSV_LO]       = c.reserved;
    w[PPC_PDN_BIT]                 = c.pll_power_down;
    w[PPC_ODRV_BIT]                = c.pll_output_drive_en;
    w[PPC_BYP_BIT]                 = c.bypass;
    cfg_word = w;
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  ppc_state_t st_r;
  ppc_state_t st_nxt;
  logic       addr_ok;

  assign addr_ok = hsel && hready && htrans == PPC_HTRANS_NSEQ && hsize == PPC_HSIZE_WORD;

  always_comb begin
    st_nxt = st_r;
    // Bus data phase: commit a pending write.
    if (st_r.wr_pend) begin
      st_nxt.wr_pend = 1'b0;
      if (st_r.wr_addr == PPC_CFG_OFFSET) begin
        st_nxt.cfg.pwm_predivide_sel   = hwdata[PPC_PSEL_HI:PPC_PSEL_LO];
        st_nxt.cfg.reserved            = hwdata[PPC_RSV_HI:PPC_RSV_LO];
        st_nxt.cfg.pll_power_down      = hwdata[PPC_PDN_BIT];
        st_nxt.cfg.pll_output_drive_en = hwdata[PPC_ODRV_BIT];
        st_nxt.cfg.bypass              = hwdata[PPC_BYP_BIT];
      end
    end
    // Bus address phase.
    st_nxt.rd_hit = 1'b0;
    if (addr_ok) begin
      if (hwrite) begin
        st_nxt.wr_pend = 1'b1;
        st_nxt.wr_addr = haddr;
      end else begin
        st_nxt.hrdata = (haddr == PPC_CFG_OFFSET) ? cfg_word(st_nxt.cfg) : '0;
      end
    end
    if (st_r.pwm_cnt >= pwm_term(st_r.cfg.pwm_predivide_sel)) begin
      st_nxt.pwm_cnt  = '0;
      st_nxt.pwm_tick = 1'b1;
    end else begin
      st_nxt.pwm_cnt  = st_r.pwm_cnt + PPC_CNT_W'(1);
      st_nxt.pwm_tick = 1'b0;
    end
    st_nxt.pll_running = !st_r.cfg.pll_power_down && !st_r.cfg.pll_output_drive_en;
    unique case (st_r.sw_state)
      PPC_SW_OSC: begin
        // The oscillator is only released once the PLL can take over.
        if (!st_r.cfg.bypass && st_r.pll_running) begin
          if (st_r.sel_osc) begin
            st_nxt.sel_osc = 1'b0;
          end else begin
            st_nxt.sel_pll  = 1'b1;
            st_nxt.sw_state = PPC_SW_PLL;
          end
        end else begin
          st_nxt.sel_osc = 1'b1;
        end
      end
      PPC_SW_PLL: begin
        if (st_r.sel_pll && (st_r.cfg.bypass || !st_r.pll_running)) begin
          st_nxt.sel_pll = 1'b0;
        end else if (!st_r.sel_pll) begin
          st_nxt.sel_osc  = 1'b1;
          st_nxt.sw_state = PPC_SW_OSC;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.cfg.pwm_predivide_sel   <= PPC_PSEL_RST;
      st_r.cfg.reserved            <= PPC_RSV_RST;
      st_r.cfg.pll_power_down      <= PPC_PDN_RST;
      st_r.cfg.pll_output_drive_en <= PPC_ODRV_RST;
      st_r.cfg.bypass              <= PPC_BYP_RST;
      st_r.wr_pend                 <= 1'b0;
      st_r.wr_addr                 <= '0;
      st_r.rd_hit                  <= 1'b0;
      st_r.hrdata                  <= '0;
      st_r.pwm_cnt                 <= '0;
      st_r.pwm_tick                <= 1'b0;
      st_r.pll_running             <= 1'b0;
      st_r.sw_state                <= PPC_SW_OSC;
      st_r.sel_osc                 <= 1'b1;
      st_r.sel_pll                 <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign hrdata              = st_r.hrdata;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign pwm_predivide_sel   = st_r.cfg.pwm_predivide_sel;
  assign pwm_clk_tick        = st_r.pwm_tick;
  assign pll_power_down      = st_r.cfg.pll_power_down;
  assign pll_output_drive_en = st_r.cfg.pll_output_drive_en;
  assign pll_running         = st_r.pll_running;
  assign sysclk_sel_osc      = st_r.sel_osc;
  assign sysclk_sel_pll      = st_r.sel_pll;

endmodule // ppc_top

// ---- verification/ppc_chk.sv ----
/* Assertion checker for the ppc_top ports.
   Assumes a bind to ppc_top with clk_en held high. */
`timescale 1ns/100ps
// ===========================================================================
// Checker
// ===========================================================================
module ppc_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic [2:0] pwm_predivide_sel,
  input wire logic       pwm_clk_tick,
  input wire logic       pll_power_down,
  input wire logic       pll_output_drive_en,
  input wire logic       pll_running,
  input wire logic       sysclk_sel_osc,
  input wire logic       sysclk_sel_pll
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [6:0] gap_r;
  logic [1:0] ok_r;
  logic [2:0] sel_q;
  logic [6:0] per_w;
  assign per_w = (pwm_predivide_sel > 3'h5) ? 7'h40 : (7'h2 << pwm_predivide_sel);
  // Two clean ticks after a select change before the period is judged.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r <= 7'h0;
      ok_r  <= 2'h0;
      sel_q <= 3'h7;
    end else begin
      gap_r <= pwm_clk_tick ? 7'h0 : gap_r + 7'h1;
      sel_q <= pwm_predivide_sel;
      if (pwm_predivide_sel != sel_q) begin
        ok_r <= 2'h0;
      end else if (pwm_clk_tick && ok_r != 2'h2) begin
        ok_r <= ok_r + 2'h1;
      end
    end
  end
  sequence s_gap;
    !sysclk_sel_osc && !sysclk_sel_pll;
  endsequence
  property p_run;
    1'b1 |=> pll_running == (!$past(pll_power_down) && !$past(pll_output_drive_en));
  endproperty
  property p_to_pll;
    $fell(sysclk_sel_osc) |-> s_gap ##1 sysclk_sel_pll;
  endproperty
  property p_to_osc;
    $fell(sysclk_sel_pll) |-> s_gap ##1 sysclk_sel_osc;
  endproperty
  property p_excl;
    !(sysclk_sel_osc && sysclk_sel_pll);
  endproperty
  property p_pll_ok;
    sysclk_sel_pll |-> $past(pll_running);
  endproperty
  property p_pulse;
    pwm_clk_tick |=> !pwm_clk_tick;
  endproperty
  property p_per;
    pwm_clk_tick && ok_r == 2'h2 && pwm_predivide_sel == sel_q |-> gap_r == per_w - 7'h1;
  endproperty
  property p_rst;
    $rose(hresetn) |-> pwm_predivide_sel == 3'h7 && pll_power_down && pll_output_drive_en
      && sysclk_sel_osc;
  endproperty
  a_run: assert property (p_run) else $error("pll running flag wrong");
  a_to_pll: assert property (p_to_pll) else $error("switch to pll bad");
  a_to_osc: assert property (p_to_osc) else $error("switch to osc bad");
  a_excl: assert property (p_excl) else $error("both selects high");
  a_pll_ok: assert property (p_pll_ok) else $error("pll selected idle");
  a_pulse: assert property (p_pulse) else $error("tick too long");
  a_per: assert property (p_per) else $error("tick period wrong");
  a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule // ppc_chk

// ---- verification/pwm_predivider_pll_control_tb.sv ----
/* Testbench for ppc_top driven over AHB-Lite.
   Assumes a zero-wait slave at 0x060 and the bound checker. */
`timescale 1ns/100ps
// ===========================================================================
// Bench
// ===========================================================================
module pwm_predivider_pll_control_tb;
  logic        hclk, hresetn, hsel, hwrite, hrdy, resp, tick, pd, oe, run, so, sp;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sel, v;
  logic [11:0] haddr;
  logic [31:0] hwdata, hrdata, rd;
  int          n_errors, compares, seed, cyc;
  ppc_top u_ppc_top (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready(hrdy), .hwdata, .hrdata, .hreadyout(hrdy), .hresp(resp),
    .pwm_predivide_sel(sel), .pwm_clk_tick(tick), .pll_power_down(pd),
    .pll_output_drive_en(oe), .pll_running(run), .sysclk_sel_osc(so), .sysclk_sel_pll(sp));
  function automatic logic [31:0] mk(logic [2:0] s, logic p, logic o, logic b);
    return {12'h0, s, 3'h0, p, o, b, 11'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // Skips two ticks so a new select has settled, then counts one period.
  task automatic tper(input int exp);
    int n;
    n = 0;
    repeat (2) begin
      @(posedge hclk);
      while (tick !== 1'b1) @(posedge hclk);
    end
    do begin
      @(posedge hclk);
      n++;
    end while (tick !== 1'b1);
    chk(n, exp);
  endtask
  task automatic close_out();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    seed = 54;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, 12'h060, 32'h0);
    chk(rd, 32'h000E3800);
    chk({sel, pd, oe, so, sp}, {3'h7, 4'hE});
    chk({resp, run, tick}, 3'h0);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      v = (i < 8) ? i[2:0] : 3'($random(seed));
      xfer(1'b1, 12'h060, mk(v, 1'b1, 1'b1, 1'b1));
      xfer(1'b0, 12'h060, 32'h0);
      chk(rd, mk(v, 1'b1, 1'b1, 1'b1));
      chk(sel, v);
      tper((v > 3'h5) ? 64 : 2 << v);
    end
    $display("divider test done");
    for (int i = 3; i >= 0; i--) begin
      xfer(1'b1, 12'h060, mk(3'h7, i[1], i[0], 1'b1));
      repeat (3) @(posedge hclk);
      chk({pd, oe, run}, {i[1:0], i == 0});
    end
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 12'h060, mk(3'h7, i == 1, 1'b0, i == 3));
      repeat (6) @(posedge hclk);
      chk({so, sp}, i[0] ? 2'h2 : 2'h1);
    end
    xfer(1'b1, 12'h064, 32'hFFFFFFFF);
    xfer(1'b0, 12'h064, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 12'h060, 32'h0);
    chk(rd, mk(3'h7, 1'b0, 1'b0, 1'b1));
    $display("pll and bus test done");
    close_out();
  end
endmodule // pwm_predivider_pll_control_tb
bind ppc_top ppc_chk u_ppc_chk (.hclk, .hresetn, .pwm_predivide_sel, .pwm_clk_tick,
  .pll_power_down, .pll_output_drive_en, .pll_running, .sysclk_sel_osc, .sysclk_sel_pll);
